// ### common/spc_pkg.sv
// Purpose: Shared constants and types of the slave parallel configuration port
// Assumes: sys_clk at 200 MHz
// Notes: Stream format is two length bytes, payload, two check bytes
package spc_pkg;

    localparam int SYS_CLK_MHZ = 200;
    localparam int PROG_MIN_NS = 500;
    // Least time, so round up
    localparam int PROG_MIN_CYC = (PROG_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int PROG_CNT_W = $clog2(PROG_MIN_CYC + 1);
    localparam int CLEAR_CYC = 64;
    localparam int WR_STALL_CYC = 3;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int ADDR_W = 16;
    localparam int PIN_W = 7;
    localparam logic [2:0] MODE_SLAVE_PAR = 3'h6;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h1021;

    typedef enum logic [3:0]
    {
        ST_CLEAR = 4'h0,
        ST_WAIT_INIT = 4'h1,
        ST_LEN_HI = 4'h2,
        ST_LEN_LO = 4'h3,
        ST_PAYLOAD = 4'h4,
        ST_CRC_HI = 4'h5,
        ST_CRC_LO = 4'h6,
        ST_DONE = 4'h7,
        ST_ERROR = 4'h8,
        ST_NO_MODE = 4'h9
    } spc_state_e;

endpackage : spc_pkg

// ### common/spc_stream_if.sv
// Purpose: Valid/ready byte stream between the port logic and its buffer
// Assumes: One clock for both sides
// Notes: Buffer modport fills from in_* and drains to out_*
interface spc_stream_if #(parameter int W = 8);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;

    modport buffer (input in_valid, output in_ready, input in_data,
                    output out_valid, input out_ready, output out_data);
    modport user (output in_valid, input in_ready, output in_data,
                  input out_valid, output out_ready, input out_data);
endinterface : spc_stream_if

// ### rtl/spc_fifo.sv
// Purpose: Byte FIFO with registered read data
// Assumes: flush is synchronous to clk
// Notes: Holds DEPTH words in storage plus one in the output register
module spc_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic flush,
    spc_stream_if.buffer st
);
    localparam int PW = $clog2(DEPTH);

    logic [W-1:0] mem_ff [DEPTH];
    logic [PW:0] wr_ptr_ff;
    logic [PW:0] rd_ptr_ff;
    logic [W-1:0] out_data_ff;
    logic out_valid_ff;
    logic empty;
    logic full;
    logic push;
    logic load;

    assign empty = (wr_ptr_ff == rd_ptr_ff);
    assign full = (wr_ptr_ff[PW] != rd_ptr_ff[PW]) && (wr_ptr_ff[PW-1:0] == rd_ptr_ff[PW-1:0]);
    assign st.in_ready = !full && !flush;
    assign push = st.in_valid && st.in_ready;
    assign load = !empty && !flush && (!out_valid_ff || st.out_ready);
    assign st.out_valid = out_valid_ff;
    assign st.out_data = out_data_ff;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_ff[wr_ptr_ff[PW-1:0]] <= st.in_data;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end
        else if (flush)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (load)
            begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            out_valid_ff <= 1'b0;
            out_data_ff <= '0;
        end
        else if (flush)
        begin
            out_valid_ff <= 1'b0;
        end
        else if (load)
        begin
            out_valid_ff <= 1'b1;
            out_data_ff <= mem_ff[rd_ptr_ff[PW-1:0]];
        end
        else if (st.out_ready)
        begin
            out_valid_ff <= 1'b0;
        end
    end

endmodule : spc_fifo

// ### rtl/spc_config_port.sv
// Purpose: Byte-wide slave configuration port with status pins
// Assumes: config_clock comes from the host; pins are asynchronous to sys_clk
// Notes: Bytes cross by a toggle handshake, then queue in a FIFO
// Contract
// - Latch mode pins when init rises; 110 loads
// - Capture data byte on config clock rising edge
// - Busy high whenever no byte can be taken
// - Pull-ups on while loading if control is 0
// - Drive select output low once configuration filled
// - Init low while clearing, released at clear end
// - Check error drives init low
// - Done held low until successful completion
// - Long program pulse restarts on its release
// - Port pins become user I/O unless kept
module spc_config_port #(
    parameter int FIFO_DEPTH = spc_pkg::FIFO_DEPTH,
    parameter int CLEAR_CYC = spc_pkg::CLEAR_CYC
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic config_clock,
    input wire logic [7:0] data_in,
    input wire logic select_n,
    input wire logic write_control_n,
    output logic busy,
    output logic busy_oe,
    output logic select_out_n,
    input wire logic [2:0] mode_in,
    input wire logic pullup_disable_in,
    output logic pullup_en,
    input wire logic init_in,
    output logic init_out,
    output logic init_oe,
    input wire logic done_in,
    output logic done_out,
    output logic done_oe,
    input wire logic program_request_n,
    input wire logic keep_port_after_load,
    output logic port_active,
    output logic cfg_wr_en,
    output logic [15:0] cfg_wr_addr,
    output logic [7:0] cfg_wr_data,
    output logic config_done,
    output logic config_error
);
    localparam int CLR_W = $clog2(CLEAR_CYC + 1);
    localparam int STL_W = $clog2(spc_pkg::WR_STALL_CYC + 1);

    function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {b, 8'h00};
        for (int i = 0; i < 8; i++)
        begin
            c = c[15] ? ((c << 1) ^ spc_pkg::CRC_POLY) : (c << 1);
        end
        return c;
    endfunction : crc_byte

    function automatic logic is_loading(input spc_pkg::spc_state_e s);
        return (s == spc_pkg::ST_LEN_HI) || (s == spc_pkg::ST_LEN_LO) ||
               (s == spc_pkg::ST_PAYLOAD) || (s == spc_pkg::ST_CRC_HI) ||
               (s == spc_pkg::ST_CRC_LO);
    endfunction : is_loading

    // Link domain
    logic acc_s1_ff;
    logic acc_s2_ff;
    logic ack_s1_ff;
    logic ack_s2_ff;
    logic req_ff;
    logic [7:0] byte_ff;
    logic link_free;

    // System domain
    logic [spc_pkg::PIN_W-1:0] pin_s1_ff;
    logic [spc_pkg::PIN_W-1:0] pin_s2_ff;
    logic prog_n_s;
    logic prog_n_d_ff;
    logic [2:0] mode_s;
    logic pud_s;
    logic init_s;
    logic done_s;
    logic [spc_pkg::PROG_CNT_W-1:0] prog_cnt_ff;
    logic restart;
    logic req_s1_ff;
    logic req_s2_ff;
    logic ack_ff;
    logic new_byte;
    logic loading_ff;
    spc_pkg::spc_state_e state_ff;
    spc_pkg::spc_state_e nxt_state;
    logic [CLR_W-1:0] clr_cnt_ff;
    logic [STL_W-1:0] stall_ff;
    logic [15:0] len_ff;
    logic [15:0] crc_ff;
    logic [7:0] crc_hi_ff;
    logic [2:0] mode_ff;
    logic take;
    logic [7:0] fbyte;

    spc_stream_if #(.W(spc_pkg::DATA_W)) st ();

    spc_fifo #(.W(spc_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo
    (
        .clk(sys_clk),
        .resetn(resetn),
        .flush(restart || (state_ff == spc_pkg::ST_CLEAR)),
        .st(st)
    );

    // Link side: a byte waits in byte_ff until the system side acknowledges it
    assign link_free = acc_s2_ff && (req_ff == ack_s2_ff);
    assign busy = !link_free;

    always_ff @(posedge config_clock or negedge resetn)
    begin
        if (!resetn)
        begin
            acc_s1_ff <= 1'b0;
            acc_s2_ff <= 1'b0;
            ack_s1_ff <= 1'b0;
            ack_s2_ff <= 1'b0;
        end
        else
        begin
            acc_s1_ff <= loading_ff;
            acc_s2_ff <= acc_s1_ff;
            ack_s1_ff <= ack_ff;
            ack_s2_ff <= ack_s1_ff;
        end
    end

    always_ff @(posedge config_clock or negedge resetn)
    begin
        if (!resetn)
        begin
            req_ff <= 1'b0;
            byte_ff <= 8'h00;
        end
        else if (link_free && !select_n && !write_control_n)
        begin
            byte_ff <= data_in;
            req_ff <= !req_ff;
        end
    end

    // Pins from outside pass two flops before use
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_s1_ff <= 7'h41;
            pin_s2_ff <= 7'h41;
            req_s1_ff <= 1'b0;
            req_s2_ff <= 1'b0;
        end
        else
        begin
            pin_s1_ff <= {program_request_n, mode_in, pullup_disable_in, init_in, done_in};
            pin_s2_ff <= pin_s1_ff;
            req_s1_ff <= req_ff;
            req_s2_ff <= req_s1_ff;
        end
    end

    assign prog_n_s = pin_s2_ff[6];
    assign mode_s = pin_s2_ff[5:3];
    assign pud_s = pin_s2_ff[2];
    assign init_s = pin_s2_ff[1];
    assign done_s = pin_s2_ff[0];

    // Short glitches on the program pin are not a restart
    assign restart = prog_n_s && !prog_n_d_ff &&
                     (prog_cnt_ff >= spc_pkg::PROG_CNT_W'(spc_pkg::PROG_MIN_CYC));

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prog_n_d_ff <= 1'b1;
            prog_cnt_ff <= '0;
        end
        else
        begin
            prog_n_d_ff <= prog_n_s;
            if (prog_n_s)
            begin
                prog_cnt_ff <= '0;
            end
            else if (prog_cnt_ff < spc_pkg::PROG_CNT_W'(spc_pkg::PROG_MIN_CYC))
            begin
                prog_cnt_ff <= prog_cnt_ff + 1'b1;
            end
        end
    end

    // Handshake: bytes arriving outside a load are acknowledged and dropped
    assign new_byte = (req_s2_ff != ack_ff);
    assign st.in_valid = new_byte && loading_ff;
    assign st.in_data = byte_ff;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ack_ff <= 1'b0;
        end
        else if (new_byte && (!loading_ff || st.in_ready))
        begin
            ack_ff <= req_s2_ff;
        end
    end

    // Loader
    assign take = is_loading(state_ff) && st.out_valid && (stall_ff == '0);
    assign st.out_ready = take;
    assign fbyte = st.out_data;

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            spc_pkg::ST_CLEAR:
            begin
                if (clr_cnt_ff == CLR_W'(CLEAR_CYC - 1))
                begin
                    nxt_state = spc_pkg::ST_WAIT_INIT;
                end
            end
            spc_pkg::ST_WAIT_INIT:
            begin
                // An outside party may hold init low to delay the start
                if (init_s)
                begin
                    nxt_state = (mode_s == spc_pkg::MODE_SLAVE_PAR) ?
                                spc_pkg::ST_LEN_HI : spc_pkg::ST_NO_MODE;
                end
            end
            spc_pkg::ST_LEN_HI:
            begin
                if (take)
                begin
                    nxt_state = spc_pkg::ST_LEN_LO;
                end
            end
            spc_pkg::ST_LEN_LO:
            begin
                if (take)
                begin
                    nxt_state = ({len_ff[15:8], fbyte} == 16'h0000) ?
                                spc_pkg::ST_CRC_HI : spc_pkg::ST_PAYLOAD;
                end
            end
            spc_pkg::ST_PAYLOAD:
            begin
                if (take && (cfg_wr_addr + 16'h0001 == len_ff))
                begin
                    nxt_state = spc_pkg::ST_CRC_HI;
                end
            end
            spc_pkg::ST_CRC_HI:
            begin
                if (take)
                begin
                    nxt_state = spc_pkg::ST_CRC_LO;
                end
            end
            spc_pkg::ST_CRC_LO:
            begin
                if (take)
                begin
                    nxt_state = ({crc_hi_ff, fbyte} == crc_ff) ?
                                spc_pkg::ST_DONE : spc_pkg::ST_ERROR;
                end
            end
            spc_pkg::ST_DONE:
            begin
                nxt_state = spc_pkg::ST_DONE;
            end
            spc_pkg::ST_ERROR:
            begin
                nxt_state = spc_pkg::ST_ERROR;
            end
            spc_pkg::ST_NO_MODE:
            begin
                nxt_state = spc_pkg::ST_NO_MODE;
            end
            default:
            begin
                nxt_state = spc_pkg::ST_CLEAR;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff <= spc_pkg::ST_CLEAR;
            loading_ff <= 1'b0;
            clr_cnt_ff <= '0;
            mode_ff <= 3'h0;
        end
        else if (restart)
        begin
            state_ff <= spc_pkg::ST_CLEAR;
            loading_ff <= 1'b0;
            clr_cnt_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            loading_ff <= is_loading(nxt_state);
            if (state_ff == spc_pkg::ST_CLEAR)
            begin
                clr_cnt_ff <= clr_cnt_ff + 1'b1;
            end
            if ((state_ff == spc_pkg::ST_WAIT_INIT) && init_s)
            begin
                mode_ff <= mode_s;
            end
        end
    end

    // Each memory write stalls the drain, so the FIFO can really fill
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stall_ff <= '0;
            len_ff <= 16'h0000;
            crc_ff <= spc_pkg::CRC_INIT;
            crc_hi_ff <= 8'h00;
            cfg_wr_en <= 1'b0;
            cfg_wr_addr <= 16'h0000;
            cfg_wr_data <= 8'h00;
        end
        else
        begin
            cfg_wr_en <= 1'b0;
            if (stall_ff != '0)
            begin
                stall_ff <= stall_ff - 1'b1;
            end
            if (restart || (state_ff == spc_pkg::ST_CLEAR))
            begin
                stall_ff <= '0;
                crc_ff <= spc_pkg::CRC_INIT;
                cfg_wr_addr <= 16'h0000;
            end
            else if (take)
            begin
                case (state_ff)
                    spc_pkg::ST_LEN_HI: len_ff[15:8] <= fbyte;
                    spc_pkg::ST_LEN_LO: len_ff[7:0] <= fbyte;
                    spc_pkg::ST_PAYLOAD:
                    begin
                        cfg_wr_en <= 1'b1;
                        cfg_wr_data <= fbyte;
                        crc_ff <= crc_byte(crc_ff, fbyte);
                        stall_ff <= STL_W'(spc_pkg::WR_STALL_CYC);
                        if (cfg_wr_en)
                        begin
                            cfg_wr_addr <= cfg_wr_addr + 16'h0001;
                        end
                    end
                    spc_pkg::ST_CRC_HI: crc_hi_ff <= fbyte;
                    default: crc_hi_ff <= crc_hi_ff;
                endcase
            end
            else if (cfg_wr_en)
            begin
                cfg_wr_addr <= cfg_wr_addr + 16'h0001;
            end
        end
    end

    // Status pins and port ownership
    assign init_out = 1'b0;
    assign init_oe = (state_ff == spc_pkg::ST_CLEAR) ||
                     (state_ff == spc_pkg::ST_ERROR);
    assign done_out = 1'b0;
    assign done_oe = (state_ff != spc_pkg::ST_DONE);
    assign select_out_n = (state_ff != spc_pkg::ST_DONE);
    assign port_active = (state_ff != spc_pkg::ST_DONE) || keep_port_after_load;
    assign busy_oe = port_active;
    assign pullup_en = (state_ff != spc_pkg::ST_DONE) && !pud_s;
    assign config_done = (state_ff == spc_pkg::ST_DONE) && done_s;
    assign config_error = (state_ff == spc_pkg::ST_ERROR) ||
                          ((state_ff == spc_pkg::ST_NO_MODE) && (mode_ff != spc_pkg::MODE_SLAVE_PAR));

endmodule : spc_config_port

// ### tb/spc_config_port_assertions.sv
// Purpose: Pin timing checks of the configuration port
// Assumes: Bound to spc_config_port
// Notes: Counters saturate, so very long pulses stay legal
module spc_config_port_assertions #(
    parameter int CLEAR_CYC = 64
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic config_clock,
    input wire logic select_n,
    input wire logic write_control_n,
    input wire logic busy,
    input wire logic select_out_n,
    input wire logic pullup_disable_in,
    input wire logic pullup_en,
    input wire logic init_oe,
    input wire logic done_oe,
    input wire logic program_request_n,
    input wire logic keep_port_after_load,
    input wire logic port_active,
    input wire logic cfg_wr_en,
    input wire logic config_error
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] prog_low_ff;
    logic [7:0] init_hi_ff;
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            prog_low_ff <= 8'h00;
        else if (program_request_n)
            prog_low_ff <= 8'h00;
        else if (prog_low_ff != 8'hff)
            prog_low_ff <= prog_low_ff + 8'h01;
    end
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            init_hi_ff <= 8'h00;
        else if (!init_oe)
            init_hi_ff <= 8'h00;
        else if (init_hi_ff != 8'hff)
            init_hi_ff <= init_hi_ff + 8'h01;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    property p_wr_gap; cfg_wr_en |=> !cfg_wr_en [*3]; endproperty
    a_wr_gap: assert property (p_wr_gap) else $error("write pulses too close");
    property p_done; !done_oe |-> !init_oe && !config_error; endproperty
    a_done: assert property (p_done) else $error("done released on failure");
    property p_sel_out; !select_out_n |-> !done_oe; endproperty
    a_sel_out: assert property (p_sel_out) else $error("select out early");
    property p_err; config_error |-> done_oe; endproperty
    a_err: assert property (p_err) else $error("error with done released");
    property p_pullup; (done_oe && !pullup_disable_in) [*4] |-> pullup_en; endproperty
    a_pullup: assert property (p_pullup) else $error("pull-ups off while loading");
    property p_port; port_active == (done_oe || keep_port_after_load); endproperty
    a_port: assert property (p_port) else $error("port kept wrongly");
    property p_prog; $rose(program_request_n) && prog_low_ff >= 8'd104
        |-> ##[1:8] (init_oe && done_oe); endproperty
    a_prog: assert property (p_prog) else $error("long program pulse ignored");
    property p_clear; $fell(init_oe) |-> init_hi_ff >= 8'(CLEAR_CYC - 2); endproperty
    a_clear: assert property (p_clear) else $error("init released early");
    property p_busy;
        @(posedge config_clock) disable iff (!resetn)
        !busy && !select_n && !write_control_n |=> busy;
    endproperty
    a_busy: assert property (p_busy) else $error("busy low after a take");
    c_write: cover property (cfg_wr_en);
    c_done: cover property (!done_oe);
    c_error: cover property (config_error);
endmodule : spc_config_port_assertions

// ### tb/spc_host_model.sv
// Purpose: Host that feeds configuration bytes
// Assumes: Link clock runs only when tick is called, inside or outside frames
// Notes: Waits on busy before each byte for up to 400 ticks, then sends the byte anyway
module spc_host_model
(
    output logic config_clock,
    output logic [7:0] data_in,
    output logic select_n,
    output logic write_control_n,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        config_clock = 1'b0;
        data_in = 8'h00;
        select_n = 1'b1;
        write_control_n = 1'b1;
    end
    task automatic tick();
        #7.5 config_clock = 1'b1;
        #7.5 config_clock = 1'b0;
    endtask : tick
    // Odd offset keeps the link phase apart from sys_clk
    task automatic open_frame();
        #1.3 select_n = 1'b0;
        write_control_n = 1'b0;
    endtask : open_frame
    // sel high makes a deliberately ignored edge
    task automatic send_byte(input logic [7:0] b, input logic sel);
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 400)
        begin
            tick();
            n++;
        end
        data_in = b;
        select_n = sel;
        tick();
        select_n = 1'b0;
    endtask : send_byte
    task automatic close_frame();
        select_n = 1'b1;
        write_control_n = 1'b1;
        data_in = ~data_in;
    endtask : close_frame
endmodule : spc_host_model

// ### tb/spc_config_port_test.sv
// Purpose: Self-checking bench of the configuration port
// Assumes: Pull-ups on the init and done pins
// Notes: Short clear time keeps the run brief
module spc_config_port_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int CLEAR_CYC = 4;
    logic sys_clk, resetn, config_clock, select_n, write_control_n, busy, busy_oe;
    logic select_out_n, pullup_disable_in, pullup_en, init_in, init_out, init_oe;
    logic done_in, done_out, done_oe, program_request_n, keep_port_after_load;
    logic port_active, cfg_wr_en, config_done, config_error;
    logic [7:0] data_in, cfg_wr_data;
    logic [15:0] cfg_wr_addr;
    logic [2:0] mode_in;
    logic [7:0] exp_mem [64];
    int err_total, comparisons, wr_idx, cyc, n;
    assign init_in = init_oe ? init_out : 1'b1;
    assign done_in = done_oe ? done_out : 1'b1;
    spc_config_port #(.CLEAR_CYC(CLEAR_CYC)) uut (.sys_clk(sys_clk), .resetn(resetn),
        .config_clock(config_clock), .data_in(data_in), .select_n(select_n),
        .write_control_n(write_control_n), .busy(busy), .busy_oe(busy_oe),
        .select_out_n(select_out_n), .mode_in(mode_in), .pullup_disable_in(pullup_disable_in),
        .pullup_en(pullup_en), .init_in(init_in), .init_out(init_out), .init_oe(init_oe),
        .done_in(done_in), .done_out(done_out), .done_oe(done_oe),
        .program_request_n(program_request_n), .keep_port_after_load(keep_port_after_load),
        .port_active(port_active), .cfg_wr_en(cfg_wr_en), .cfg_wr_addr(cfg_wr_addr),
        .cfg_wr_data(cfg_wr_data), .config_done(config_done), .config_error(config_error));
    spc_host_model host (.config_clock(config_clock), .data_in(data_in), .select_n(select_n),
        .write_control_n(write_control_n), .busy(busy));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {b, 8'h00};
        for (int k = 0; k < 8; k++)
            r = r[15] ? ((r << 1) ^ spc_pkg::CRC_POLY) : (r << 1);
        return r;
    endfunction : crc_step
    // Bad frames flip the check word; one ignored edge follows the third payload byte, if the frame has one
    task automatic send_frame(input int len, input logic bad);
        logic [15:0] crc;
        logic [7:0] b;
        crc = spc_pkg::CRC_INIT;
        wr_idx = 0;
        host.open_frame();
        host.send_byte(len[15:8], 1'b0);
        host.send_byte(len[7:0], 1'b0);
        for (int i = 0; i < len; i++)
        begin
            b = 8'(i * 29 + 60);
            exp_mem[i] = b;
            crc = crc_step(crc, b);
            host.send_byte(b, 1'b0);
            if (i == 2)
                host.send_byte(8'hee, 1'b1);
        end
        if (bad)
            crc = ~crc;
        host.send_byte(crc[15:8], 1'b0);
        host.send_byte(crc[7:0], 1'b0);
        host.close_frame();
    endtask : send_frame
    task automatic restart(input int len);
        program_request_n = 1'b0;
        repeat (len) @(negedge sys_clk);
        program_request_n = 1'b1;
        repeat (8) @(negedge sys_clk);
    endtask : restart
    task automatic wait_loading();
        for (n = 0; n < 300 && init_oe !== 1'b0; n++)
            @(negedge sys_clk);
    endtask : wait_loading
    task automatic wait_end();
        for (n = 0; n < 3000 && done_oe !== 1'b0 && config_error !== 1'b1; n++)
            @(negedge sys_clk);
        // The done pin reaches config_done only after its two sync flops
        repeat (3) @(negedge sys_clk);
    endtask : wait_end
    // Sampled mid-cycle, away from the edge that launches the write
    always @(negedge sys_clk)
        if (cfg_wr_en === 1'b1)
        begin
            check(cfg_wr_addr, wr_idx[15:0]);
            check({8'h00, cfg_wr_data}, {8'h00, exp_mem[wr_idx % 64]});
            wr_idx++;
        end
    // A ceiling well past the longest expected run
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            err_total++;
            end_of_test();
        end
    end
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial
    begin
        err_total = 0;
        comparisons = 0;
        cyc = 0;
        wr_idx = 0;
        resetn = 1'b0;
        program_request_n = 1'b1;
        mode_in = 3'h6;
        pullup_disable_in = 1'b0;
        keep_port_after_load = 1'b0;
        repeat (8) @(negedge sys_clk);
        host.tick();
        check({init_oe, done_oe, select_out_n, busy}, 16'h000f);
        check({init_out, done_out}, 16'h0000);
        repeat (5) @(negedge sys_clk);
        resetn = 1'b1;
        wait_loading();
        check(init_oe, 1'b0);
        check(pullup_en, 1'b1);
        send_frame(12, 1'b0);
        wait_end();
        check({done_oe, select_out_n, init_oe, config_error}, 16'h0000);
        check({config_done, pullup_en, port_active}, 16'h0004);
        check(wr_idx[15:0], 16'h000c);
        pullup_disable_in = 1'b1;
        restart(50);
        check(done_oe, 1'b0);
        restart(120);
        check(done_oe, 1'b1);
        wait_loading();
        check(pullup_en, 1'b0);
        send_frame(5, 1'b1);
        wait_end();
        check({config_error, init_oe, done_oe}, 16'h0007);
        mode_in = 3'h7;
        restart(120);
        repeat (40) @(negedge sys_clk);
        host.tick();
        host.tick();
        check({config_error, busy, done_oe}, 16'h0007);
        mode_in = 3'h6;
        keep_port_after_load = 1'b1;
        pullup_disable_in = 1'b0;
        restart(120);
        wait_loading();
        send_frame(0, 1'b0);
        wait_end();
        check({done_oe, port_active, busy_oe}, 16'h0003);
        end_of_test();
    end
endmodule : spc_config_port_test
bind spc_config_port spc_config_port_assertions #(.CLEAR_CYC(CLEAR_CYC)) u_chk (
    .sys_clk(sys_clk), .resetn(resetn), .config_clock(config_clock), .select_n(select_n),
    .write_control_n(write_control_n), .busy(busy), .select_out_n(select_out_n),
    .pullup_disable_in(pullup_disable_in), .pullup_en(pullup_en), .init_oe(init_oe),
    .done_oe(done_oe), .program_request_n(program_request_n),
    .keep_port_after_load(keep_port_after_load), .port_active(port_active),
    .cfg_wr_en(cfg_wr_en), .config_error(config_error));
